//--- coe_addr_pkg.sv
// Constants and types for coefficient memory block addressing
package coe_addr_pkg;
	// ==========================================================
	// Geometry
	localparam int          WORD_COUNT      = 40;
	localparam int          BLOCK_COUNT     = 5;
	localparam int          BLOCK_WORDS     = 8;
	localparam int          ADDR_W          = 6;
	localparam int          BLK_W           = 3;
	localparam int          IDX_W           = 3;
	localparam int          DATA_W          = 16;
	localparam logic [2:0]  IDX_FIRST       = 3'h7;
	localparam logic [2:0]  IDX_LAST        = 3'h0;
	localparam logic [2:0]  BLK_HIGHEST     = 3'h4;
	// ==========================================================
	// Block allocation
	localparam logic [2:0]  BLK_RECEIVE     = 3'h4;
	localparam logic [2:0]  BLK_TRANSMIT    = 3'h3;
	localparam logic [2:0]  BLK_TWO         = 3'h2;
	localparam logic [2:0]  BLK_ONE         = 3'h1;
	localparam logic [2:0]  BLK_ZERO        = 3'h0;
	localparam logic [2:0]  GAIN_IDX_LOW    = 3'h4;
	// ==========================================================
	// Coefficient set selects
	typedef enum logic [2:0] {
		SET_NONE,
		SET_RECEIVE_GAIN,
		SET_RECEIVE_FREQ_RESPONSE,
		SET_TRANSMIT_GAIN,
		SET_TRANSMIT_FREQ_RESPONSE,
		SET_BLOCK_TWO,
		SET_BLOCK_ONE,
		SET_BLOCK_ZERO
	} coef_set_t;
endpackage

//--- coe_mem_if.sv
// Interface between the sequencer and the coefficient memory
`timescale 1ns/10ps
interface coe_mem_if;
	import coe_addr_pkg::*;
	logic                we;
	logic [ADDR_W-1:0]   addr;
	logic [DATA_W-1:0]   wdata;
	logic [DATA_W-1:0]   rdata;
	modport master (output we, output addr, output wdata, input rdata);
	modport memory (input we, input addr, input wdata, output rdata);
endinterface

//--- coe_word_mem.sv
// Coefficient memory of forty words with registered read data
`timescale 1ns/10ps
module coe_word_mem
	import coe_addr_pkg::*;
(
	input  wire logic    mclk_i,
	input  wire logic    ce_i,
	coe_mem_if.memory    mem
);
	// ==========================================================
	// Storage
	logic [DATA_W-1:0] words_r [WORD_COUNT];
	logic [DATA_W-1:0] rdata_r;

	always_ff @(posedge mclk_i) begin
		if (ce_i && mem.we && (mem.addr < ADDR_W'(WORD_COUNT))) begin
			words_r[mem.addr] <= mem.wdata;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (ce_i) begin
			if (mem.addr < ADDR_W'(WORD_COUNT)) begin
				rdata_r <= words_r[mem.addr];
			end else begin
				rdata_r <= '0;
			end
		end
	end

	assign mem.rdata = rdata_r;
endmodule

//--- coe_block_seq.sv
// Block-addressed sequencer for the coefficient memory
`timescale 1ns/10ps
// Behaviour
// - Forty words in five eight-word blocks
// - Six-bit address: block high, word low
// - Command carries only three-bit block number and write flag
// - One command walks all eight block words
// - Word index counts seven down to zero
// - Block four: receive gain plus frequency response
// - Block three transmit sets; blocks two-zero single
module coe_block_seq
	import coe_addr_pkg::*;
(
	input  wire logic               mclk_i,
	input  wire logic               nrst_i,
	input  wire logic               ce_i,
	input  wire logic               cmd_valid_i,
	input  wire logic               cmd_write_i,
	input  wire logic [BLK_W-1:0]   cmd_block_i,
	output logic                    cmd_ready_o,
	output logic                    cmd_reject_o,
	input  wire logic               wr_valid_i,
	input  wire logic [DATA_W-1:0]  wr_data_i,
	output logic                    wr_ready_o,
	output logic                    rd_valid_o,
	output logic [DATA_W-1:0]       rd_data_o,
	output logic [ADDR_W-1:0]       word_addr_o,
	output logic [2:0]              coef_set_o,
	output logic                    done_o
);
	typedef enum logic [1:0] {ST_IDLE, ST_WRITE, ST_READ, ST_READ_LAST} state_t;

	state_t            state_r;
	logic [BLK_W-1:0]  block_r;
	logic [IDX_W-1:0]  idx_r;
	logic              rd_pend_r;
	logic              cmd_take;
	logic              cmd_bad;
	logic              wr_take;
	logic              step;
	coef_set_t         set_nxt;

	coe_mem_if mem ();

	coe_word_mem u_mem (
		.mclk_i (mclk_i),
		.ce_i   (ce_i),
		.mem    (mem)
	);

	// ==========================================================
	// Command acceptance
	assign cmd_bad  = cmd_block_i > BLK_HIGHEST;
	assign cmd_take = ce_i && cmd_valid_i && (state_r == ST_IDLE) && !cmd_bad;
	assign wr_take  = ce_i && (state_r == ST_WRITE) && wr_valid_i;
	assign step     = wr_take || (ce_i && (state_r == ST_READ));

	assign mem.addr  = {block_r, idx_r};
	assign mem.we    = wr_take;
	assign mem.wdata = wr_data_i;

	// ==========================================================
	// Sequencer
	always_ff @(posedge mclk_i) begin
		if (!nrst_i) begin
			state_r <= ST_IDLE;
			block_r <= BLK_ZERO;
			idx_r   <= IDX_FIRST;
		end else if (ce_i) begin
			case (state_r)
				ST_IDLE: begin
					if (cmd_take) begin
						block_r <= cmd_block_i;
						idx_r   <= IDX_FIRST;
						state_r <= cmd_write_i ? ST_WRITE : ST_READ;
					end
				end
				ST_WRITE: begin
					if (wr_valid_i) begin
						if (idx_r == IDX_LAST) begin
							state_r <= ST_IDLE;
						end else begin
							idx_r <= idx_r - 3'h1;
						end
					end
				end
				ST_READ: begin
					if (idx_r == IDX_LAST) begin
						state_r <= ST_READ_LAST;
					end else begin
						idx_r <= idx_r - 3'h1;
					end
				end
				ST_READ_LAST: begin
					state_r <= ST_IDLE;
				end
				default: begin
					state_r <= ST_IDLE;
				end
			endcase
		end
	end

	// ==========================================================
	// Coefficient set of the current word
	always_comb begin
		case (block_r)
			BLK_RECEIVE: begin
				set_nxt = (idx_r >= GAIN_IDX_LOW) ? SET_RECEIVE_GAIN : SET_RECEIVE_FREQ_RESPONSE;
			end
			BLK_TRANSMIT: begin
				set_nxt = (idx_r >= GAIN_IDX_LOW) ? SET_TRANSMIT_GAIN : SET_TRANSMIT_FREQ_RESPONSE;
			end
			BLK_TWO: set_nxt = SET_BLOCK_TWO;
			BLK_ONE: set_nxt = SET_BLOCK_ONE;
			BLK_ZERO: set_nxt = SET_BLOCK_ZERO;
			default: set_nxt = SET_NONE;
		endcase
	end

	// ==========================================================
	// Registered outputs
	always_ff @(posedge mclk_i) begin
		if (!nrst_i) begin
			cmd_ready_o  <= 1'b0;
			cmd_reject_o <= 1'b0;
			wr_ready_o   <= 1'b0;
			rd_pend_r    <= 1'b0;
			rd_valid_o   <= 1'b0;
			rd_data_o    <= '0;
			word_addr_o  <= '0;
			coef_set_o   <= SET_NONE;
			done_o       <= 1'b0;
		end else if (ce_i) begin
			cmd_ready_o  <= (state_r == ST_IDLE) && !cmd_valid_i ||
				(state_r == ST_READ_LAST) || (state_r == ST_WRITE && wr_valid_i && idx_r == IDX_LAST);
			cmd_reject_o <= cmd_valid_i && (state_r == ST_IDLE) && cmd_bad;
			wr_ready_o   <= (state_r == ST_IDLE) ? (cmd_take && cmd_write_i) :
				(state_r == ST_WRITE) && !(wr_valid_i && idx_r == IDX_LAST);
			rd_pend_r    <= (state_r == ST_READ);
			rd_valid_o   <= rd_pend_r;
			rd_data_o    <= rd_pend_r ? mem.rdata : rd_data_o;
			word_addr_o  <= step ? mem.addr : word_addr_o;
			coef_set_o   <= step ? set_nxt : coef_set_o;
			done_o       <= (state_r == ST_READ_LAST) ||
				(wr_take && idx_r == IDX_LAST);
		end
	end

	// ==========================================================
	// Checks
	AST_BAD_BLOCK_REJECT: assert property (@(posedge mclk_i) disable iff (!nrst_i)
		ce_i && cmd_valid_i && state_r == ST_IDLE && cmd_block_i > BLK_HIGHEST
		|=> cmd_reject_o && state_r == ST_IDLE)
		else $error("Unallocated block not rejected");
	AST_START_HIGH: assert property (@(posedge mclk_i) disable iff (!nrst_i)
		cmd_take |=> idx_r == IDX_FIRST && block_r == $past(cmd_block_i))
		else $error("Walk did not start at highest word");
	AST_DOWN_COUNT: assert property (@(posedge mclk_i) disable iff (!nrst_i)
		step && idx_r != IDX_LAST |=> idx_r == $past(idx_r) - 3'h1)
		else $error("Word index did not decrement");
	AST_READ_EIGHT: assert property (@(posedge mclk_i) disable iff (!nrst_i)
		cmd_take && !cmd_write_i && ce_i |=> (state_r == ST_READ) [*8] ##1 state_r == ST_READ_LAST)
		else $error("Read walk not eight words");
	AST_ADDR_SPLIT: assert property (@(posedge mclk_i) disable iff (!nrst_i)
		step |=> word_addr_o[5:3] == $past(block_r) && word_addr_o[2:0] == $past(idx_r))
		else $error("Address fields wrong");
	AST_IN_RANGE: assert property (@(posedge mclk_i) disable iff (!nrst_i)
		state_r != ST_IDLE |-> block_r <= BLK_HIGHEST)
		else $error("Address beyond forty words");
	AST_RX_SHARED: assert property (@(posedge mclk_i) disable iff (!nrst_i)
		step && block_r == BLK_RECEIVE && idx_r < GAIN_IDX_LOW
		|=> coef_set_o == SET_RECEIVE_FREQ_RESPONSE)
		else $error("Receive block split wrong");
	AST_TX_SPLIT: assert property (@(posedge mclk_i) disable iff (!nrst_i)
		step && block_r == BLK_TRANSMIT && idx_r >= GAIN_IDX_LOW |=> coef_set_o == SET_TRANSMIT_GAIN)
		else $error("Transmit block split wrong");
	AST_READ_DATA: assert property (@(posedge mclk_i) disable iff (!nrst_i)
		ce_i && state_r == ST_READ ##1 ce_i |=> rd_valid_o)
		else $error("Read data not delivered");
	AST_WRITE_END: assert property (@(posedge mclk_i) disable iff (!nrst_i)
		wr_take && idx_r == IDX_LAST |=> done_o && state_r == ST_IDLE && !wr_ready_o)
		else $error("Write walk did not end after last word");
	AST_WRITE_OPEN: assert property (@(posedge mclk_i) disable iff (!nrst_i)
		cmd_take && cmd_write_i |=> wr_ready_o && state_r == ST_WRITE)
		else $error("Write walk did not open");
	AST_DONE_PULSE: assert property (@(posedge mclk_i) disable iff (!nrst_i)
		done_o && ce_i |=> !done_o)
		else $error("Done held beyond one cycle");
	AST_FIRST_WORD: assert property (@(posedge mclk_i) disable iff (!nrst_i)
		cmd_take ##1 step |=> word_addr_o[2:0] == IDX_FIRST)
		else $error("First word not the highest");
	AST_READ_TURN: assert property (@(posedge mclk_i) disable iff (!nrst_i)
		ce_i && state_r == ST_READ && idx_r == IDX_LAST |=> state_r == ST_READ_LAST)
		else $error("Read walk ran past word zero");
	AST_TAKE_NO_REJECT: assert property (@(posedge mclk_i) disable iff (!nrst_i)
		cmd_take |=> !cmd_reject_o)
		else $error("Accepted command also rejected");
	AST_BUSY_IGNORED: assert property (@(posedge mclk_i) disable iff (!nrst_i)
		ce_i && cmd_valid_i && state_r != ST_IDLE |=> block_r == $past(block_r))
		else $error("Command taken while busy");
	AST_CE_FREEZE: assert property (@(posedge mclk_i) disable iff (!nrst_i)
		!ce_i |=> $stable(state_r) && $stable(idx_r) &&
		$stable(cmd_reject_o) && $stable(done_o))
		else $error("State moved while clock enable low");
	AST_RX_GAIN: assert property (@(posedge mclk_i) disable iff (!nrst_i)
		step && block_r == BLK_RECEIVE && idx_r >= GAIN_IDX_LOW
		|=> coef_set_o == SET_RECEIVE_GAIN)
		else $error("Receive gain words wrong");
	AST_TX_FREQ: assert property (@(posedge mclk_i) disable iff (!nrst_i)
		step && block_r == BLK_TRANSMIT && idx_r < GAIN_IDX_LOW
		|=> coef_set_o == SET_TRANSMIT_FREQ_RESPONSE)
		else $error("Transmit response words wrong");
	AST_SINGLE_SET: assert property (@(posedge mclk_i) disable iff (!nrst_i)
		step && block_r == BLK_TWO |=> coef_set_o == SET_BLOCK_TWO)
		else $error("Block two set wrong");
	COV_WRITE_WALK: cover property (@(posedge mclk_i) disable iff (!nrst_i)
		cmd_take && cmd_write_i ##[1:40] done_o);
	COV_READ_WALK: cover property (@(posedge mclk_i) disable iff (!nrst_i)
		cmd_take && !cmd_write_i ##[1:20] done_o);
	COV_REJECT: cover property (@(posedge mclk_i) disable iff (!nrst_i) cmd_reject_o);
	COV_BUSY_CMD: cover property (@(posedge mclk_i) disable iff (!nrst_i)
		ce_i && cmd_valid_i && state_r == ST_READ);
	COV_WRITE_STALL: cover property (@(posedge mclk_i) disable iff (!nrst_i)
		ce_i && state_r == ST_WRITE && !wr_valid_i);
endmodule

//--- coe_host.sv
// Host model issuing block commands and write words
`timescale 1ns/10ps
module coe_host
	import coe_addr_pkg::*;
(
	input  wire logic         mclk_i,
	input  wire logic         wr_ready_i,
	output logic              cmd_valid_o,
	output logic              cmd_write_o,
	output logic [BLK_W-1:0]  cmd_block_o,
	output logic              wr_valid_o,
	output logic [DATA_W-1:0] wr_data_o
);
	// ==========================================================
	// Drive at falling edge, lines inverted when released
	initial begin
		cmd_valid_o = 1'b0;
		cmd_write_o = 1'b0;
		cmd_block_o = 3'h0;
		wr_valid_o = 1'b0;
		wr_data_o = 16'h0000;
	end
	task send_cmd(input logic wr, input logic [2:0] blk);
		cmd_valid_o = 1'b1;
		cmd_write_o = wr;
		cmd_block_o = blk;
		@(negedge mclk_i);
		cmd_valid_o = 1'b0;
		cmd_write_o = ~wr;
		cmd_block_o = ~blk;
	endtask
	task send_word(input logic [DATA_W-1:0] d, input logic stall);
		if (stall) begin
			wr_valid_o = 1'b0;
			@(negedge mclk_i);
		end
		wr_valid_o = 1'b1;
		wr_data_o = d;
		while (wr_ready_i !== 1'b1) @(negedge mclk_i);
		@(negedge mclk_i);
	endtask
	task end_words;
		wr_valid_o = 1'b0;
		wr_data_o = ~wr_data_o;
	endtask
endmodule

//--- coefficient_ram_block_addressing_tb_top.sv
// Self-checking bench for the block sequencer
`timescale 1ns/10ps
module coefficient_ram_block_addressing_tb_top;
	import coe_addr_pkg::*;
	logic              mclk_i, nrst_i, ce_i, cv, cw, wv, crdy, crej, wrdy, rv, done;
	logic [BLK_W-1:0]  cb;
	logic [DATA_W-1:0] wd, rd, sh [0:WORD_COUNT-1], mem_q[$];
	logic [ADDR_W-1:0] wa, pa;
	logic [2:0]        cs;
	logic [8:0]        addr_q[$];
	int                err_count, compares, cycles;
	coe_block_seq i_dut (.mclk_i(mclk_i), .nrst_i(nrst_i), .ce_i(ce_i), .cmd_valid_i(cv),
		.cmd_write_i(cw), .cmd_block_i(cb), .cmd_ready_o(crdy), .cmd_reject_o(crej),
		.wr_valid_i(wv), .wr_data_i(wd), .wr_ready_o(wrdy), .rd_valid_o(rv), .rd_data_o(rd),
		.word_addr_o(wa), .coef_set_o(cs), .done_o(done));
	coe_host i_host (.mclk_i(mclk_i), .wr_ready_i(wrdy), .cmd_valid_o(cv), .cmd_write_o(cw),
		.cmd_block_o(cb), .wr_valid_o(wv), .wr_data_o(wd));
	// ==========================================================
	// Helpers
	function logic [2:0] eset(input logic [2:0] b, input logic [2:0] i);
		case (b)
			3'h4: return (i >= 3'h4) ? SET_RECEIVE_GAIN : SET_RECEIVE_FREQ_RESPONSE;
			3'h3: return (i >= 3'h4) ? SET_TRANSMIT_GAIN : SET_TRANSMIT_FREQ_RESPONSE;
			3'h2: return SET_BLOCK_TWO;
			3'h1: return SET_BLOCK_ONE;
			3'h0: return SET_BLOCK_ZERO;
			default: return SET_NONE;
		endcase
	endfunction
	task check(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task close_out;
		$display("compares %0d err_count %0d", compares, err_count);
		if (err_count == 0 && compares > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	task walk(input logic w, input logic [2:0] b);
		logic [DATA_W-1:0] d [0:7];
		int i;
		int n;
		for (i = 7; i >= 0; i--) begin
			addr_q.push_back({b, i[2:0], eset(b, i[2:0])});
			d[i] = DATA_W'($urandom);
			if (w) sh[{b, i[2:0]}] = d[i];
			else mem_q.push_back(sh[{b, i[2:0]}]);
		end
		check(16'(crdy), 16'h0001);
		i_host.send_cmd(w, b);
		check(16'(crdy), 16'h0000);
		if (!w) begin
			@(negedge mclk_i);
			i_host.send_cmd(1'b1, 3'h0);
		end
		for (i = 7; i >= 0 && w; i--) i_host.send_word(d[i], $urandom_range(1, 0) == 1);
		if (w) i_host.end_words();
		n = 0;
		while (done !== 1'b1 && n < 40) begin
			@(negedge mclk_i);
			n++;
		end
		check(16'(n < 40), 16'h0001);
	endtask
	// ==========================================================
	// Monitor and timeout
	always @(negedge mclk_i) begin
		if (rv === 1'b1) begin
			if (mem_q.size() == 0) check(rd, ~rd);
			else check(rd, mem_q.pop_front());
		end
		if (wa !== pa) begin
			if (addr_q.size() == 0) check({wa, cs}, 16'hffff);
			else check({wa, cs}, addr_q.pop_front());
		end
		pa <= wa;
	end
	always @(posedge mclk_i) begin
		cycles++;
		if (cycles == 5000) begin
			err_count++;
			close_out();
		end
	end
	initial begin
		mclk_i = 1'b0;
		forever #50 mclk_i = ~mclk_i;
	end
	// ==========================================================
	// Main sequence
	initial begin
		void'($urandom(73769));
		nrst_i = 1'b0;
		ce_i = 1'b1;
		pa = 6'h00;
		repeat (4) @(negedge mclk_i);
		nrst_i = 1'b1;
		@(negedge mclk_i);
		for (int b = 0; b < 5; b++) walk(1'b1, 3'(b));
		for (int b = 4; b >= 0; b--) walk(1'b0, 3'(b));
		for (int b = 5; b < 8; b++) begin
			i_host.send_cmd($urandom_range(1, 0) == 1, 3'(b));
			check(16'(crej), 16'h0001);
			@(negedge mclk_i);
			check(16'(crej), 16'h0000);
		end
		ce_i = 1'b0;
		i_host.send_cmd(1'b0, 3'h5);
		check(16'(crej), 16'h0000);
		ce_i = 1'b1;
		@(negedge mclk_i);
		walk(1'b1, 3'h4);
		walk(1'b0, 3'h4);
		repeat (4) @(negedge mclk_i);
		check(16'(mem_q.size() + addr_q.size()), 16'h0000);
		close_out();
	end
endmodule
